// ### rtl/idesc_consts.vh
// constants for the secondary ide channel pin block
`ifndef IDESC_CONSTS_VH
`define IDESC_CONSTS_VH
// i/o decode ranges (upper bits compared, low three bits select the byte)
`define IDESC_CMD_BASE 16'h0170
`define IDESC_CTL_BASE 16'h0370
`define IDESC_RANGE_MASK 16'hFFF8
// strobe timing in ns, converted to cycles at 10 ns clock
`define IDESC_CLK_NS 10
`define IDESC_SETUP_NS 30
`define IDESC_PULSE_NS 100
`define IDESC_RECOVER_NS 60
`define IDESC_CYC(ns) ((((ns) + `IDESC_CLK_NS - 1) / `IDESC_CLK_NS) < 1 ? \
   1 : (((ns) + `IDESC_CLK_NS - 1) / `IDESC_CLK_NS))
// fifo shape
`define IDESC_FIFO_DEPTH 8
`define IDESC_DATA_W 16
`endif

// ### rtl/idesc_fifo.v
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module idesc_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire clock,
   input wire reset,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_ff;
   reg [AW-1:0] rd_ptr_ff;
   reg [AW:0] count_ff;
   wire push;
   wire pop;

   // full and empty come straight from the occupancy count
   assign in_ready = (count_ff != DEPTH[AW:0]);
   assign out_valid = (count_ff != {(AW+1){1'b0}});
   assign out_data = mem[rd_ptr_ff];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // storage has no reset; only pointers and count need a defined state
   always @(posedge clock) begin
      if (push) begin
         mem[wr_ptr_ff] <= in_data;
      end
   end

   // pointers wrap at depth, so depth need not be a power of two
   always @(posedge clock) begin
      if (reset) begin
         wr_ptr_ff <= {AW{1'b0}};
         rd_ptr_ff <= {AW{1'b0}};
         count_ff <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ?
               {AW{1'b0}} : wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ?
               {AW{1'b0}} : rd_ptr_ff + 1'b1;
         end
         if (push & ~pop) begin
            count_ff <= count_ff + 1'b1;
         end else if (pop & ~push) begin
            count_ff <= count_ff - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ### rtl/idesc_port.v
// secondary ide channel pin engine: pio register cycles and bus-master dma
// Functional notes
// - drive three address lines selecting byte within command/control block.
// - command chip select low only for 170h-177h accesses.
// - control chip select low only for 370h-377h accesses.
// - data bus driven for writes, released for reads.
// - dma acknowledge low marks strobe cycle as dma transfer.
// - acknowledge comes only from bus-master engine, never legacy dma.
// - dual-channel mode serves the secondary connector.
// - master/slave mode serves the primary-slave connector with same pins.
// - drive selected by chip selects plus address, or by acknowledge.
`timescale 1ns/1ns
`default_nettype none
`include "idesc_consts.vh"
module idesc_port #(
   parameter SETUP_CYC = `IDESC_CYC(`IDESC_SETUP_NS),
   parameter PULSE_CYC = `IDESC_CYC(`IDESC_PULSE_NS),
   parameter RECOVER_CYC = `IDESC_CYC(`IDESC_RECOVER_NS),
   parameter DEPTH = `IDESC_FIFO_DEPTH
) (
   input wire clock,
   input wire reset,
   // pio request from the host side
   input wire pio_req,
   input wire pio_write,
   input wire [15:0] pio_addr,
   input wire [15:0] pio_wdata,
   output wire pio_ready,
   output reg pio_done,
   output reg [15:0] pio_rdata,
   // bus-master engine control
   input wire bm_enable,
   input wire bm_write,
   input wire [15:0] bm_wdata,
   input wire bm_wvalid,
   output wire bm_wready,
   output wire [15:0] bm_rdata,
   output wire bm_rvalid,
   input wire bm_rready,
   // connector role strap: 0 secondary, 1 primary-slave
   input wire slave_mode,
   output reg serving_primary_slave,
   // drive pins
   output reg [2:0] drive_addr,
   output reg drive_addr_oe_n,
   output reg command_block_select_n,
   output reg control_block_select_n,
   input wire [15:0] drive_data_in,
   output reg [15:0] drive_data_out,
   output reg drive_data_oe_n,
   output reg drive_dma_ack_n,
   input wire drive_dma_request,
   input wire drive_iordy,
   output reg drive_read_strobe_n,
   output reg drive_write_strobe_n
);
   //--------------------------------------------------------------
   // state and synchronisers
   //--------------------------------------------------------------
   localparam S_IDLE = 4'b0001;
   localparam S_SETUP = 4'b0010;
   localparam S_PULSE = 4'b0100;
   localparam S_RECOV = 4'b1000;

   reg [3:0] state_ff;
   reg [7:0] cnt_ff;
   reg is_dma_ff;
   reg is_wr_ff;
   reg [1:0] dreq_sync_ff;
   reg [1:0] rdy_sync_ff;
   reg [15:0] rdata_ff;
   wire dreq_s;
   wire rdy_s;
   wire cmd_hit;
   wire ctl_hit;
   wire rf_valid;
   wire rf_ready;
   wire wf_valid;
   wire [15:0] wf_data;
   wire dma_go;
   reg rf_push;
   reg wf_pop;

   // request and iordy pins from the drive pass two flops before use; data is sampled directly
   always @(posedge clock) begin
      if (reset) begin
         dreq_sync_ff <= 2'h0;
         rdy_sync_ff <= 2'h0;
      end else begin
         dreq_sync_ff <= {dreq_sync_ff[0], drive_dma_request};
         rdy_sync_ff <= {rdy_sync_ff[0], drive_iordy};
      end
   end
   assign dreq_s = dreq_sync_ff[1];
   assign rdy_s = rdy_sync_ff[1];

   always @(posedge clock) begin
      serving_primary_slave <= slave_mode;
   end

   //--------------------------------------------------------------
   // dma data buffering
   //--------------------------------------------------------------
   // write data from engine to drive
   idesc_fifo #(.WIDTH(16), .DEPTH(DEPTH), .AW(3)) u_wfifo (
      .clock(clock), .reset(reset),
      .in_valid(bm_wvalid), .in_ready(bm_wready), .in_data(bm_wdata),
      .out_valid(wf_valid), .out_ready(wf_pop), .out_data(wf_data)
   );
   // read data from drive to engine; full fifo stalls new dma read cycles
   idesc_fifo #(.WIDTH(16), .DEPTH(DEPTH), .AW(3)) u_rfifo (
      .clock(clock), .reset(reset),
      .in_valid(rf_push), .in_ready(rf_ready), .in_data(rdata_ff),
      .out_valid(bm_rvalid), .out_ready(bm_rready), .out_data(bm_rdata)
   );
   assign rf_valid = rf_ready;

   //--------------------------------------------------------------
   // decode
   //--------------------------------------------------------------
   // command block range
   assign cmd_hit = ((pio_addr & `IDESC_RANGE_MASK) == `IDESC_CMD_BASE);
   assign ctl_hit = ((pio_addr & `IDESC_RANGE_MASK) == `IDESC_CTL_BASE);
   // dma only on drive request with engine on and room to move
   assign dma_go = bm_enable & dreq_s &
      (bm_write ? wf_valid : rf_valid);
   // pio wins ties since it is the cpu waiting; unmapped address answered at once with FFFF
   assign pio_ready = (state_ff == S_IDLE) & ~reset;

   //--------------------------------------------------------------
   // cycle sequencer
   //--------------------------------------------------------------
   always @(posedge clock) begin
      rf_push <= 1'b0;
      wf_pop <= 1'b0;
      pio_done <= 1'b0;
      if (reset) begin
         // selects high, address and data float
         state_ff <= S_IDLE;
         cnt_ff <= 8'h00;
         is_dma_ff <= 1'b0;
         is_wr_ff <= 1'b0;
         rdata_ff <= 16'h0000;
         pio_rdata <= 16'h0000;
         drive_addr <= 3'h0;
         drive_addr_oe_n <= 1'b1;
         drive_data_out <= 16'h0000;
         drive_data_oe_n <= 1'b1;
         command_block_select_n <= 1'b1;
         control_block_select_n <= 1'b1;
         drive_dma_ack_n <= 1'b1;
         drive_read_strobe_n <= 1'b1;
         drive_write_strobe_n <= 1'b1;
      end else begin
         case (state_ff)
            S_IDLE: begin
               drive_addr_oe_n <= 1'b0;
               if (pio_req & (cmd_hit | ctl_hit)) begin
                  drive_addr <= pio_addr[2:0];
                  // select by chip select plus address
                  command_block_select_n <= ~cmd_hit;
                  control_block_select_n <= ~ctl_hit;
                  is_dma_ff <= 1'b0;
                  is_wr_ff <= pio_write;
                  drive_data_out <= pio_wdata;
                  drive_data_oe_n <= ~pio_write;
                  cnt_ff <= SETUP_CYC[7:0];
                  state_ff <= S_SETUP;
               end else if (pio_req) begin
                  pio_done <= 1'b1;
                  pio_rdata <= 16'hFFFF;
               end else if (dma_go) begin
                  // acknowledge only from the bus-master engine
                  drive_dma_ack_n <= 1'b0;
                  is_dma_ff <= 1'b1;
                  is_wr_ff <= bm_write;
                  drive_data_out <= wf_data;
                  drive_data_oe_n <= ~bm_write;
                  wf_pop <= bm_write;
                  cnt_ff <= SETUP_CYC[7:0];
                  state_ff <= S_SETUP;
               end
            end
            S_SETUP: begin
               if (cnt_ff <= 8'h01) begin
                  // strobe under acknowledge is a dma transfer
                  drive_read_strobe_n <= is_wr_ff;
                  drive_write_strobe_n <= ~is_wr_ff;
                  cnt_ff <= PULSE_CYC[7:0];
                  state_ff <= S_PULSE;
               end else begin
                  cnt_ff <= cnt_ff - 8'h01;
               end
            end
            S_PULSE: begin
               // iordy low stretches the strobe
               if (cnt_ff > 8'h01) begin
                  cnt_ff <= cnt_ff - 8'h01;
               end else if (rdy_s) begin
                  drive_read_strobe_n <= 1'b1;
                  drive_write_strobe_n <= 1'b1;
                  rdata_ff <= drive_data_in;
                  if (!is_dma_ff) begin
                     pio_rdata <= drive_data_in;
                  end
                  rf_push <= is_dma_ff & ~is_wr_ff;
                  cnt_ff <= RECOVER_CYC[7:0];
                  state_ff <= S_RECOV;
               end
            end
            S_RECOV: begin
               if (cnt_ff <= 8'h01) begin
                  command_block_select_n <= 1'b1;
                  control_block_select_n <= 1'b1;
                  drive_dma_ack_n <= 1'b1;
                  drive_data_oe_n <= 1'b1;
                  pio_done <= ~is_dma_ff;
                  state_ff <= S_IDLE;
               end else begin
                  cnt_ff <= cnt_ff - 8'h01;
               end
            end
            default: begin
               state_ff <= S_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ### bench/idesc_drive_model.sv
// behavioural ata drive facing the pin engine
`timescale 1ns/1ns
`default_nettype none
// ----
// drive
// ----
module idesc_drive_model (
   input wire logic clock,
   input wire logic req_on,
   input wire logic slow,
   input wire logic [2:0] drive_addr,
   input wire logic command_block_select_n,
   input wire logic control_block_select_n,
   input wire logic [15:0] drive_data_out,
   input wire logic drive_dma_ack_n,
   input wire logic drive_read_strobe_n,
   input wire logic drive_write_strobe_n,
   output logic [15:0] drive_data_in,
   output logic drive_dma_request,
   output logic drive_iordy
);
   logic [15:0] regs [16];
   logic [15:0] dma_got [$];
   logic [15:0] last = 16'h0000;
   logic [15:0] rd_count = 16'h0000;
   int wait_cnt = 0;
   wire [3:0] idx = {!control_block_select_n, drive_addr};
   assign drive_dma_request = req_on;
   // slow drive holds iordy low for four cycles of each strobe
   always @(posedge clock) begin
      wait_cnt <= (drive_read_strobe_n && drive_write_strobe_n) ?
         0 : wait_cnt + 1;
      if (!drive_read_strobe_n)
         last <= drive_data_in;
   end
   assign drive_iordy = !slow || wait_cnt >= 4;
   // bus carries read data only in read strobe, inverted last read word otherwise
   always @* begin
      if (!drive_read_strobe_n)
         drive_data_in = drive_dma_ack_n ? regs[idx] : 16'hA000 + rd_count;
      else
         drive_data_in = ~last;
   end
   always @(posedge drive_read_strobe_n) begin
      if (!drive_dma_ack_n)
         rd_count = rd_count + 16'h0001;
   end
   // selected by ack or chip selects
   always @(posedge drive_write_strobe_n) begin
      if (!drive_dma_ack_n)
         dma_got.push_back(drive_data_out);
      else if (!command_block_select_n || !control_block_select_n)
         regs[idx] = drive_data_out;
   end
endmodule
`default_nettype wire

// ### bench/idesc_port_checker.sv
// concurrent checks on the pin engine ports
`timescale 1ns/1ns
`default_nettype none
// ----
// checker
// ----
module idesc_port_checker (
   input wire logic clock,
   input wire logic reset,
   input wire logic [15:0] pio_addr,
   input wire logic bm_enable,
   input wire logic slave_mode,
   input wire logic serving_primary_slave,
   input wire logic [2:0] drive_addr,
   input wire logic drive_addr_oe_n,
   input wire logic command_block_select_n,
   input wire logic control_block_select_n,
   input wire logic drive_data_oe_n,
   input wire logic drive_dma_ack_n,
   input wire logic drive_read_strobe_n,
   input wire logic drive_write_strobe_n
);
   wire no_sel = command_block_select_n && control_block_select_n;
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   AST_CMD_RANGE:
   assert property ($fell(command_block_select_n) |->
      $past(pio_addr[15:3]) == 13'h002E) else $error("bad command select");
   AST_CTL_RANGE:
   assert property ($fell(control_block_select_n) |->
      $past(pio_addr[15:3]) == 13'h006E) else $error("bad control select");
   AST_ADDR:
   assert property (!no_sel && $past(no_sel) |->
      drive_addr == $past(pio_addr[2:0])) else $error("bad address");
   AST_ACK_SRC:
   assert property ($fell(drive_dma_ack_n) |-> $past(bm_enable))
      else $error("ack without engine");
   AST_ACK_ALONE:
   assert property (!drive_dma_ack_n |-> no_sel) else $error("ack with select");
   AST_STROBE_SEL:
   assert property (!(drive_read_strobe_n && drive_write_strobe_n) |->
      !no_sel || !drive_dma_ack_n) else $error("strobe unselected");
   AST_WR_DRIVE:
   assert property (!drive_write_strobe_n |-> !drive_data_oe_n)
      else $error("write not driven");
   AST_RD_FLOAT:
   assert property (!drive_read_strobe_n |-> drive_data_oe_n)
      else $error("read driven");
   AST_ROLE:
   assert property (serving_primary_slave == $past(slave_mode))
      else $error("role not followed");
   AST_RESET_IDLE:
   assert property (disable iff (1'b0) reset |=> no_sel && drive_dma_ack_n
      && drive_addr_oe_n && drive_data_oe_n) else $error("reset not idle");
   cover property ($fell(command_block_select_n));
   cover property ($fell(control_block_select_n));
   cover property ($fell(drive_dma_ack_n));
endmodule
bind idesc_port idesc_port_checker i_chk (.clock, .reset, .pio_addr,
   .bm_enable, .slave_mode, .serving_primary_slave, .drive_addr,
   .drive_addr_oe_n, .command_block_select_n, .control_block_select_n,
   .drive_data_oe_n, .drive_dma_ack_n, .drive_read_strobe_n,
   .drive_write_strobe_n);
`default_nettype wire

// ### bench/ide_secondary_channel_pins_test.sv
// self-checking bench for the pin engine
`timescale 1ns/1ns
`default_nettype none
// ----
// bench
// ----
module ide_secondary_channel_pins_test;
   logic clock = 0, reset = 1, pio_req = 0, pio_write = 0, slow = 0;
   logic bm_enable = 0, bm_write = 0, bm_wvalid = 0, bm_rready = 0;
   logic slave_mode = 0, req_on = 0;
   logic [15:0] pio_addr = 16'h0000, pio_wdata = 16'h0000;
   logic [15:0] bm_wdata = 16'h0000, rd, w;
   wire pio_ready, pio_done, bm_wready, bm_rvalid, serving_primary_slave;
   wire [15:0] pio_rdata, bm_rdata, drive_data_in, drive_data_out;
   wire [2:0] drive_addr;
   wire drive_addr_oe_n, command_block_select_n, control_block_select_n;
   wire drive_data_oe_n, drive_dma_ack_n, drive_dma_request, drive_iordy;
   wire drive_read_strobe_n, drive_write_strobe_n;
   int miscompares = 0, checks_done = 0, seed = 84, i, n;
   logic [15:0] ref_mem [int];
   logic [15:0] exp_q [$];
   always #5 clock = ~clock;
   idesc_port i_dut (.clock, .reset, .pio_req, .pio_write, .pio_addr,
      .pio_wdata, .pio_ready, .pio_done, .pio_rdata, .bm_enable, .bm_write,
      .bm_wdata, .bm_wvalid, .bm_wready, .bm_rdata, .bm_rvalid, .bm_rready,
      .slave_mode, .serving_primary_slave, .drive_addr, .drive_addr_oe_n,
      .command_block_select_n, .control_block_select_n, .drive_data_in,
      .drive_data_out, .drive_data_oe_n, .drive_dma_ack_n,
      .drive_dma_request, .drive_iordy, .drive_read_strobe_n,
      .drive_write_strobe_n);
   idesc_drive_model i_drv (.clock, .req_on, .slow, .drive_addr,
      .command_block_select_n, .control_block_select_n, .drive_data_out,
      .drive_dma_ack_n, .drive_read_strobe_n, .drive_write_strobe_n,
      .drive_data_in, .drive_dma_request, .drive_iordy);
   task automatic chk(input string what, input logic [15:0] e, g);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // one register access, request held over its taking edge
   task automatic pio(input logic wr, input logic [15:0] a, d);
      @(posedge clock);
      pio_req <= 1'b1;
      pio_write <= wr;
      pio_addr <= a;
      pio_wdata <= d;
      #1 chk("ready", 16'h0001, {15'h0000, pio_ready});
      @(posedge clock);
      pio_req <= 1'b0;
      n = 0;
      // an unmapped access answers at the taking edge, so look first
      #1;
      while (pio_done !== 1'b1 && n < 100) begin
         @(posedge clock);
         #1 n++;
      end
      rd = pio_rdata;
      if (n >= 100) begin
         miscompares++;
         tally_and_finish;
      end
   endtask
   initial begin
      repeat (8) @(posedge clock);
      reset <= 1'b0;
      for (i = 0; i < 8; i++) begin
         ref_mem[i] = 16'($random(seed));
         pio(1'b1, 16'h0170 + i[15:0], ref_mem[i]);
      end
      for (i = 0; i < 8; i++) begin
         pio(1'b0, 16'h0170 + i[15:0], 16'h0000);
         chk("command reg", ref_mem[i], rd);
      end
      w = 16'($random(seed));
      pio(1'b1, 16'h0376, w);
      slow <= 1'b1;
      pio(1'b0, 16'h0376, 16'h0000);
      chk("control reg", w, rd);
      pio(1'b0, 16'h0178, 16'h0000);
      chk("unmapped", 16'hFFFF, rd);
      // second reset mid-run, drive keeps its registers
      @(posedge clock);
      reset <= 1'b1;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      slave_mode <= 1'b1;
      pio(1'b0, 16'h0170, 16'h0000);
      chk("after reset", ref_mem[0], rd);
      chk("role", 16'h0001, {15'h0000, serving_primary_slave});
      // buffer must refuse the ninth word while the engine is off
      for (i = 0; i < 9; i++) begin
         @(posedge clock);
         bm_wvalid <= 1'b1;
         bm_wdata <= 16'($random(seed));
         @(negedge clock);
         if (bm_wready) exp_q.push_back(bm_wdata);
      end
      @(posedge clock);
      bm_wvalid <= 1'b0;
      slave_mode <= 1'b0;
      chk("fill", 16'h0008, 16'(exp_q.size()));
      bm_write <= 1'b1;
      bm_enable <= 1'b1;
      req_on <= 1'b1;
      for (n = 0; n < 2000 && i_drv.dma_got.size() < 8; n++)
         @(posedge clock);
      req_on <= 1'b0;
      if (n >= 2000) begin
         miscompares++;
         tally_and_finish;
      end
      for (i = 0; i < 8; i++)
         chk("dma write", exp_q[i], i_drv.dma_got[i]);
      chk("role", 16'h0000, {15'h0000, serving_primary_slave});
      // read engine fills its buffer against a stalled drain, then drains
      @(posedge clock);
      bm_write <= 1'b0;
      req_on <= 1'b1;
      repeat (300) @(posedge clock);
      i = 0;
      for (n = 0; i < 12 && n < 2000; n++) begin
         @(posedge clock);
         bm_rready <= 1'($random(seed));
         @(negedge clock);
         if (bm_rvalid && bm_rready) begin
            chk("dma read", 16'hA000 + i[15:0], bm_rdata);
            i++;
         end
      end
      req_on <= 1'b0;
      if (n >= 2000) miscompares++;
      tally_and_finish;
   end
endmodule
`default_nettype wire
